// >>> rtl/iosp_consts.svh
// Constants for the I/O output and stack pop execution block.
`ifndef IOSP_CONSTS_SVH
`define IOSP_CONSTS_SVH
`define IOSP_STACK_DEPTH    8
`define IOSP_WORD_W         16
`define IOSP_ADDR_W         16
// Cycle costs.
`define IOSP_ORLK_INT_CYC   2
`define IOSP_ORLK_EXT_BASE  2
`define IOSP_ORLK_EXT_PMUL  2
`define IOSP_SINGLE_ACCESS_RAM_PENALTY  1
// Register map.
`define IOSP_REG_CMD        8'h00
`define IOSP_REG_OPER       8'h04
`define IOSP_REG_PRODUCT_REGISTER       8'h08
`define IOSP_REG_CTRL       8'h0c
`define IOSP_REG_ACC        8'h10
`define IOSP_REG_TOS        8'h14
`define IOSP_REG_STAT       8'h18
`define IOSP_REG_CYC        8'h1c
`define IOSP_REG_PUSH       8'h20
// Command codes.
`define IOSP_CMD_OUT        3'h1
`define IOSP_CMD_PAC        3'h2
`define IOSP_CMD_POP        3'h3
`define IOSP_CMD_POP_TO_MEMORY_INSTR       3'h4
`define IOSP_CMD_ORLK       3'h5
// Control field positions.
`define IOSP_CTRL_PM_LO     0
`define IOSP_CTRL_EXTP      2
`define IOSP_CTRL_SAME      3
`define IOSP_CTRL_WAIT_LO   4
`endif

// >>> rtl/iosp_exec.sv
// Executes port output, product load, stack pops and long-immediate OR timing.
// How it works
// [RQ1] Port output reads one data word and writes it to the given port.
// [RQ2] Port output drives the I/O space select low during the access.
// [RQ3] Port output uses the external write strobe, direction and ready handshake.
// [RQ4] Product load puts the shifted product register into the accumulator.
// [RQ5] Stack pop moves the top into the low accumulator, then pops.
// [RQ6] Pop to memory stores the top at the operand address, then pops.
// [RQ7] Each pop shifts every lower entry up one place.
// [RQ8] Underflow is neither detected nor flagged.
// [RQ9] Long-immediate OR takes two cycles internal, two plus twice waits external.
// [RQ10] Operand and code in one single-access block add a cycle.
// [RQ11] Eight 16-bit entries; the bottom entry keeps its value on pop.
// [RQ12] Port number and data stand on the external buses for the whole write.
`timescale 1ns/100ps
`include "iosp_consts.svh"
module iosp_exec
  import iosp_pkg::*;
(
  input  wire logic          clk,        // Core clock, 25 MHz.
  input  wire logic          rst,        // Asynchronous reset, active high.
  input  wire logic [7:0]    paddr,      // APB address.
  input  wire logic          psel,       // APB select.
  input  wire logic          penable,    // APB enable.
  input  wire logic          pwrite,     // APB direction.
  input  wire logic [31:0]   pwdata,     // APB write data.
  output logic      [31:0]   prdata,     // APB read data.
  output logic               pready,     // APB ready.
  output logic               pslverr,    // APB error.
  input  wire logic          ext_ready,  // Wait-ready input from the pins.
  output iosp_ext_t          ext,        // External bus pins.
  output logic      [15:0]   dmem_raddr, // Data-memory read address.
  input  wire logic [15:0]   dmem_rdata, // Data-memory read data.
  output iosp_dmem_wr_t      dmem_wr     // Data-memory write.
);
  // ==========================================================================
  // Register interface
  // ==========================================================================
  logic        [15:0] oper_addr;
  logic        [15:0] port_number;
  logic        [31:0] product_register;
  logic        [1:0]  product_shift_field;
  logic               ext_prog;
  logic               same_block;
  logic        [3:0]  wait_states;
  logic        [31:0] acc;
  logic        [15:0] top_of_stack;
  logic        [7:0]  cycles_used;
  logic        [7:0]  cyc_cnt;
  logic        [7:0]  cyc_target;
  logic               busy;
  logic               done_flag;
  logic        [31:0] shifted;
  logic               wr_acc;
  logic               rd_acc;
  logic               cmd_go;
  logic        [2:0]  cmd_code;
  logic               stk_push;
  logic               stk_pop;
  logic        [15:0] push_word;
  logic               ready_s1;
  logic               ready_s2;
  iosp_state_t        state;
  iosp_state_t        next_state;
  logic               count_end;
  logic               finishing;
  logic               out_go;
  logic               or_go;
  logic        [15:0] bus_addr;
  logic        [15:0] bus_data;
  logic               bus_rw;
  logic               bus_sel_n;
  logic               bus_strobe_n;

  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign cmd_go  = wr_acc && (paddr == `IOSP_REG_CMD) && !busy;
  assign cmd_code = pwdata[2:0];

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      case (paddr)
        `IOSP_REG_CMD, `IOSP_REG_OPER, `IOSP_REG_PRODUCT_REGISTER, `IOSP_REG_CTRL,
        `IOSP_REG_ACC, `IOSP_REG_TOS, `IOSP_REG_STAT, `IOSP_REG_CYC,
        `IOSP_REG_PUSH: pslverr = 1'b0;
        default:        pslverr = 1'b1;
      endcase
    end
  end

  // Only the operand, product and control registers are stored here; command
  // and push writes act at once and are dropped while a sequence runs.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oper_addr           <= 16'h0000;
      port_number         <= 16'h0000;
      product_register    <= 32'h0000_0000;
      product_shift_field <= 2'h0;
      ext_prog            <= 1'b0;
      same_block          <= 1'b0;
      wait_states         <= 4'h0;
    end else if (wr_acc) begin
      case (paddr)
        `IOSP_REG_OPER: begin
          oper_addr   <= pwdata[15:0];
          port_number <= pwdata[31:16];
        end
        `IOSP_REG_PRODUCT_REGISTER: product_register <= pwdata;
        `IOSP_REG_CTRL: begin
          product_shift_field <= pwdata[`IOSP_CTRL_PM_LO +: 2];
          ext_prog            <= pwdata[`IOSP_CTRL_EXTP];
          same_block          <= pwdata[`IOSP_CTRL_SAME];
          wait_states         <= pwdata[`IOSP_CTRL_WAIT_LO +: 4];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `IOSP_REG_OPER: prdata <= {port_number, oper_addr};
        `IOSP_REG_PRODUCT_REGISTER: prdata <= product_register;
        `IOSP_REG_CTRL: prdata <= {24'h00_0000, wait_states, same_block, ext_prog,
                                   product_shift_field};
        `IOSP_REG_ACC:  prdata <= acc;
        `IOSP_REG_TOS:  prdata <= {16'h0000, top_of_stack};
        `IOSP_REG_STAT: prdata <= {29'h0000_0000, state != IOSP_ST_IDLE, done_flag, busy};
        `IOSP_REG_CYC:  prdata <= {24'h00_0000, cycles_used};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Ready synchroniser
  // ==========================================================================
  // The ready pin is not timed to the core clock, so two flip-flops keep a
  // metastable level away from the sequencer.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_s1 <= 1'b0;
      ready_s2 <= 1'b0;
    end else begin
      ready_s1 <= ext_ready;
      ready_s2 <= ready_s1;
    end
  end

  // ==========================================================================
  // Datapath helpers
  // ==========================================================================
  iosp_shift u_shift (
    .product_register    (product_register),
    .product_shift_field (product_shift_field),
    .shifted             (shifted)
  );

  assign push_word = pwdata[15:0];
  assign stk_push  = wr_acc && (paddr == `IOSP_REG_PUSH) && !busy;
  assign stk_pop   = cmd_go && (cmd_code == `IOSP_CMD_POP || cmd_code == `IOSP_CMD_POP_TO_MEMORY_INSTR);

  iosp_stack #(
    .DEPTH (`IOSP_STACK_DEPTH),
    .W     (`IOSP_WORD_W)
  ) u_stack (
    .clk       (clk),
    .rst       (rst),
    .push      (stk_push),
    .push_data (push_word),
    .pop       (stk_pop), // [RQ5] [RQ6]
    .top       (top_of_stack)
  );

  // ==========================================================================
  // Accumulator and data-memory write
  // ==========================================================================
  // Both pops read the old top in the same cycle as the stack shifts, so the
  // value moved out is always the one that stood before the command.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc <= 32'h0000_0000;
    end else if (cmd_go && cmd_code == `IOSP_CMD_PAC) begin
      acc <= shifted; // [RQ4]
    end else if (cmd_go && cmd_code == `IOSP_CMD_POP) begin
      acc <= {16'h0000, top_of_stack}; // [RQ5]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dmem_wr <= '0;
    end else if (cmd_go && cmd_code == `IOSP_CMD_POP_TO_MEMORY_INSTR) begin
      dmem_wr <= '{we: 1'b1, addr: oper_addr, wdata: top_of_stack}; // [RQ6]
    end else begin
      dmem_wr.we <= 1'b0;
    end
  end

  assign dmem_raddr = oper_addr; // [RQ1]

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  assign busy      = state != IOSP_ST_IDLE;
  assign out_go    = cmd_go && cmd_code == `IOSP_CMD_OUT;
  assign or_go     = cmd_go && cmd_code == `IOSP_CMD_ORLK;
  assign count_end = cyc_cnt + 8'h01 >= cyc_target;
  assign finishing = state == IOSP_ST_RELEASE || (state == IOSP_ST_COUNT && count_end);

  // A write cycle ends only after the synchronised ready has been seen, so a
  // slow peripheral can stretch the strobe for as long as it needs.
  always_comb begin
    next_state = state;
    case (state)
      IOSP_ST_IDLE: begin
        if (out_go) begin
          next_state = IOSP_ST_SETUP;
        end else if (or_go) begin
          next_state = IOSP_ST_COUNT;
        end
      end
      IOSP_ST_SETUP: begin
        next_state = IOSP_ST_STROBE;
      end
      IOSP_ST_STROBE: begin
        if (ready_s2) begin
          next_state = IOSP_ST_RELEASE; // [RQ3]
        end
      end
      IOSP_ST_RELEASE: begin
        next_state = IOSP_ST_IDLE;
      end
      IOSP_ST_COUNT: begin
        if (count_end) begin
          next_state = IOSP_ST_IDLE; // [RQ9]
        end
      end
      default: begin
        next_state = IOSP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= IOSP_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // The target is latched as the command is taken, so a later control write
  // cannot change the length of a count already running.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_target <= 8'h00;
    end else if (or_go) begin
      if (ext_prog) begin
        cyc_target <= 8'(`IOSP_ORLK_EXT_BASE + `IOSP_ORLK_EXT_PMUL * wait_states); // [RQ9]
      end else begin
        cyc_target <= 8'(`IOSP_ORLK_INT_CYC); // [RQ9]
      end
    end
  end

  // The counter runs in every busy state and restarts whenever the
  // sequencer is idle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_cnt <= 8'h00;
    end else if (state == IOSP_ST_IDLE) begin
      cyc_cnt <= 8'h00;
    end else begin
      cyc_cnt <= cyc_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cycles_used <= 8'h00;
      done_flag   <= 1'b0;
    end else if (finishing) begin
      // Same-block conflict costs an extra cycle. [RQ10]
      cycles_used <= cyc_cnt + 8'h01 + (same_block ? 8'(`IOSP_SINGLE_ACCESS_RAM_PENALTY) : 8'h00);
      done_flag   <= 1'b1;
    end else if (cmd_go) begin
      done_flag   <= 1'b0;
    end
  end

  // ==========================================================================
  // External bus
  // ==========================================================================
  // Port number and data are loaded once, as the command is taken, and are
  // then left alone so that they stand for the whole write cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_addr <= 16'h0000;
      bus_data <= 16'h0000;
    end else if (out_go) begin
      bus_addr <= port_number; // [RQ12]
      bus_data <= dmem_rdata;  // [RQ1]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_rw    <= 1'b1;
      bus_sel_n <= 1'b1;
    end else if (out_go) begin
      bus_rw    <= 1'b0; // [RQ3]
      bus_sel_n <= 1'b0; // [RQ2]
    end else if (state == IOSP_ST_RELEASE) begin
      bus_rw    <= 1'b1;
      bus_sel_n <= 1'b1; // [RQ2]
    end
  end

  // The strobe opens one cycle after select and direction settle, and closes
  // one cycle before they are released.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_strobe_n <= 1'b1;
    end else if (state == IOSP_ST_SETUP) begin
      bus_strobe_n <= 1'b0; // [RQ3]
    end else if (state == IOSP_ST_STROBE && ready_s2) begin
      bus_strobe_n <= 1'b1; // [RQ3]
    end
  end

  assign ext = '{addr: bus_addr, data: bus_data, strobe_n: bus_strobe_n, rw: bus_rw,
                 io_space_select_n: bus_sel_n};
endmodule // iosp_exec

// >>> rtl/iosp_pkg.sv
// Types for the I/O output and stack pop execution block.
package iosp_pkg;
  typedef enum logic [2:0] {
    IOSP_ST_IDLE,
    IOSP_ST_SETUP,
    IOSP_ST_STROBE,
    IOSP_ST_RELEASE,
    IOSP_ST_COUNT
  } iosp_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic        strobe_n;
    logic        rw;
    logic        io_space_select_n;
  } iosp_ext_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } iosp_dmem_wr_t;
endpackage

// >>> rtl/iosp_shift.sv
// Product shifter selected by the product shift field.
`timescale 1ns/100ps
module iosp_shift (
  input  wire logic [31:0] product_register,    // Product value.
  input  wire logic [1:0]  product_shift_field, // Shift mode.
  output logic      [31:0] shifted              // Shifted product.
);
  always_comb begin
    case (product_shift_field)
      2'h1:    shifted = {product_register[30:0], 1'b0};
      2'h2:    shifted = {product_register[27:0], 4'h0};
      2'h3:    shifted = {{6{product_register[31]}}, product_register[31:6]};
      default: shifted = product_register;
    endcase
  end
endmodule // iosp_shift

// >>> rtl/iosp_stack.sv
// Eight-level hardware stack with push and shift-up pop.
`timescale 1ns/100ps
`include "iosp_consts.svh"
module iosp_stack #(
  parameter int DEPTH = `IOSP_STACK_DEPTH,
  parameter int W     = `IOSP_WORD_W
) (
  input  wire logic         clk,       // Core clock.
  input  wire logic         rst,       // Asynchronous reset.
  input  wire logic         push,      // Push one word.
  input  wire logic [W-1:0] push_data, // Word pushed.
  input  wire logic         pop,       // Pop one level.
  output logic      [W-1:0] top        // Top of stack.
);
  logic [W-1:0] entry [DEPTH];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        entry[i] <= '0;
      end
    end else if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        entry[i] <= entry[i+1]; // [RQ7] [RQ8]
      end
      // The bottom entry keeps its value. [RQ11]
    end else if (push) begin
      entry[0] <= push_data;
      for (int i = 1; i < DEPTH; i++) begin
        entry[i] <= entry[i-1];
      end
    end
  end

  assign top = entry[0];
endmodule // iosp_stack

// >>> verif/iosp_exec_asserts.sv
// Assertions on the ports of the execution block.
`timescale 1ns/100ps
module iosp_exec_asserts
  import iosp_pkg::*;
(
  input wire logic          clk,        // Clock.
  input wire logic          rst,        // Reset.
  input wire logic [7:0]    paddr,      // Address.
  input wire logic          psel,       // Select.
  input wire logic          penable,    // Enable.
  input wire logic          pwrite,     // Direction.
  input wire logic [31:0]   pwdata,     // Write data.
  input wire logic          pslverr,    // Error.
  input wire logic          ext_ready,  // Ready.
  input wire iosp_ext_t     ext,        // External bus.
  input wire logic [15:0]   dmem_raddr, // Memory address.
  input wire logic [15:0]   dmem_rdata, // Memory data.
  input wire iosp_dmem_wr_t dmem_wr     // Memory write.
);
  // =====
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic cmd_w;
  assign cmd_w = psel && penable && pwrite && paddr == 8'h00;
  a_strobe_io: assert property (
    !ext.strobe_n |-> !ext.io_space_select_n && !ext.rw) else $error("strobe outside io");
  a_bus_stable: assert property (
    !ext.io_space_select_n && !$past(ext.io_space_select_n)
    |-> $stable(ext.addr) && $stable(ext.data)) else $error("io bus moved");
  a_strobe_follows: assert property (
    $fell(ext.io_space_select_n) |=> $fell(ext.strobe_n)) else $error("no strobe");
  a_strobe_release: assert property (
    !ext.strobe_n && ext_ready |-> ##[0:4] ext.strobe_n) else $error("strobe stuck");
  a_io_data: assert property (
    $fell(ext.io_space_select_n) |-> ext.data == $past(dmem_rdata)) else $error("io data");
  a_pop_to_memory_instr_cause: assert property (
    dmem_wr.we |-> $past(cmd_w && pwdata[2:0] == 3'h4)) else $error("stray store");
  a_pop_to_memory_instr_addr: assert property (
    dmem_wr.we |-> dmem_wr.addr == $past(dmem_raddr)) else $error("store address");
  a_cmd_no_err: assert property (
    psel && penable && paddr == 8'h00 |-> !pslverr) else $error("command error");
endmodule // iosp_exec_asserts

bind iosp_exec iosp_exec_asserts u_chk (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pslverr(pslverr),
  .ext_ready(ext_ready), .ext(ext), .dmem_raddr(dmem_raddr), .dmem_rdata(dmem_rdata),
  .dmem_wr(dmem_wr));

// >>> verif/iosp_io_periph.sv
// Peripheral model on the external I/O port space.
`timescale 1ns/100ps
module iosp_io_periph
  import iosp_pkg::*;
(
  input  wire logic       clk,       // Clock.
  input  wire logic       rst,       // Reset.
  input  wire iosp_ext_t  ext,       // External bus.
  input  wire logic [3:0] lat,       // Wait cycles.
  output logic            ext_ready, // Ready.
  output logic [15:0]     got_port,  // Port seen.
  output logic [15:0]     got_data,  // Data seen.
  output logic [1:0]      got_flags, // Direction, select.
  output int              got_cnt    // Writes seen.
);
  // =====
  // Ready rises lat cycles into the strobe and holds until it ends.
  logic [3:0] cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      ext_ready <= 1'b0;
      got_cnt <= 0;
    end else if (!ext.strobe_n) begin
      got_port <= ext.addr;
      got_data <= ext.data;
      got_flags <= {ext.rw, ext.io_space_select_n};
      if (cnt == 4'h0)
        got_cnt <= got_cnt + 1;
      if (cnt >= lat)
        ext_ready <= 1'b1;
      if (cnt != 4'hf)
        cnt <= cnt + 4'h1;
    end else begin
      cnt <= 4'h0;
      ext_ready <= 1'b0;
    end
  end
endmodule // iosp_io_periph

// >>> verif/tb_top.sv
// Self-checking testbench for the execution block.
`timescale 1ns/100ps
module tb_top;
  import iosp_pkg::*;
  logic          clk, rst, psel, penable, pwrite, pready, pslverr, ext_ready, erv;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rdv, wlast;
  logic [15:0]   dmem_raddr, dmem_rdata, gport, gdata, stk [8];
  logic [1:0]    gflags;
  logic [3:0]    lat;
  iosp_ext_t     ext;
  iosp_dmem_wr_t dmem_wr;
  int            fails, cmp_count, gcnt, wcnt, seed;

  iosp_exec i_dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_ready(ext_ready), .ext(ext), .dmem_raddr(dmem_raddr), .dmem_rdata(dmem_rdata),
    .dmem_wr(dmem_wr));
  iosp_io_periph i_per (.clk(clk), .rst(rst), .ext(ext), .lat(lat), .ext_ready(ext_ready),
    .got_port(gport), .got_data(gdata), .got_flags(gflags), .got_cnt(gcnt));

  // =====
  // Clock, memory and helpers
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [15:0] mem(input logic [15:0] a);
    return a ^ 16'hc3a5;
  endfunction
  function automatic logic [31:0] pacx(input logic [31:0] p, input logic [1:0] m);
    case (m)
      2'h0: return p;
      2'h1: return p << 1;
      2'h2: return p << 4;
      default: return $signed(p) >>> 6;
    endcase
  endfunction
  always @(posedge clk) begin
    dmem_rdata <= mem(dmem_raddr);
    if (dmem_wr.we === 1'b1) begin
      wcnt <= wcnt + 1;
      wlast <= {dmem_wr.addr, dmem_wr.wdata};
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 64);
    if (n == 64) fails++;
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin apb(1'b0, 8'h18, 0); n++; end while (rdv[0] !== 1'b0 && n < 200);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic spop();
    for (int i = 0; i < 7; i++) stk[i] = stk[i + 1];
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end

  // =====
  // Tests
  initial begin
    logic [31:0] v;
    int p, xp, same, w0;
    seed = 32'h656b; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 0; lat = 4'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h14, 0);
    chk("tos_reset", 0, rdv);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      if (k == 3) v[31] = 1'b1;
      apb(1'b1, 8'h08, v);
      apb(1'b1, 8'h0c, k);
      apb(1'b1, 8'h00, 32'h2);
      apb(1'b0, 8'h10, 0);
      chk("acc_pac", pacx(v, 2'(k)), rdv);
    end
    $display("test product done");
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      apb(1'b1, 8'h20, v);
      for (int j = 7; j > 0; j--) stk[j] = stk[j - 1];
      stk[0] = v[15:0];
    end
    v = $random(seed);
    apb(1'b1, 8'h04, v);
    w0 = wcnt;
    apb(1'b1, 8'h00, 32'h4);
    apb(1'b0, 8'h14, 0);
    chk("store_cnt", w0 + 1, wcnt);
    chk("store", {v[15:0], stk[0]}, wlast);
    spop();
    chk("tos_pop_to_memory_instr", 32'(stk[0]), 32'(rdv[15:0]));
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, 8'h00, 32'h3);
      chk("pop_err", 0, 32'(erv));
      apb(1'b0, 8'h10, 0);
      chk("acc_pop", 32'(stk[0]), rdv);
      spop();
    end
    apb(1'b0, 8'h14, 0);
    chk("tos_bottom", 32'(stk[0]), 32'(rdv[15:0]));
    $display("test stack done");
    for (int k = 0; k < 3; k++) begin
      v = $random(seed);
      lat <= 4'(k * 3);
      apb(1'b1, 8'h04, v);
      apb(1'b1, 8'h00, 32'h1);
      idle();
      chk("port", 32'(v[31:16]), 32'(gport));
      chk("data", 32'(mem(v[15:0])), 32'(gdata));
      chk("flags", 0, 32'(gflags));
      chk("writes", k + 1, gcnt);
    end
    $display("test output done");
    for (int k = 0; k < 6; k++) begin
      p = $random(seed) & 15;
      if (k == 1) p = 15;
      xp = k % 2;
      same = k / 2 % 2;
      apb(1'b1, 8'h0c, {24'h0, 4'(p), 1'(same), 1'(xp), 2'h0});
      apb(1'b1, 8'h00, 32'h5);
      idle();
      chk("done", 1, 32'(rdv[1]));
      apb(1'b0, 8'h1c, 0);
      chk("cycles", (xp == 1 ? 2 + 2 * p : 2) + same, rdv);
    end
    $display("test timing done");
    apb(1'b0, 8'h40, 0);
    chk("unmapped_err", 1, 32'(erv));
    chk("unmapped_data", 0, rdv);
    $display("test unmapped done");
    conclude();
  end
endmodule // tb_top
